/* File: isc_defines.svh */
// Constants for the IDE strap configuration block: register offsets,
// field positions, reset values and fixed codes.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef ISC_DEFINES_SVH
`define ISC_DEFINES_SVH

`define ISC_OFF_STRAP    12'h000
`define ISC_OFF_CMD      12'h004
`define ISC_OFF_CLASS    12'h008
`define ISC_OFF_BAR0     12'h010
`define ISC_OFF_BAR3     12'h01C
`define ISC_OFF_SUBSYS   12'h02C
`define ISC_OFF_CHAN     12'h050

`define ISC_CMD_IO_BIT    0
`define ISC_CMD_ROM_BIT   1
`define ISC_PI_PRI_NAT    0
`define ISC_PI_PRI_CAP    1
`define ISC_PI_SEC_NAT    2
`define ISC_PI_SEC_CAP    3
`define ISC_CHAN_PRI_BIT  2
`define ISC_CHAN_SEC_BIT  3

`define ISC_SUBCLASS_RAID 8'h04
`define ISC_SUBCLASS_IDE  8'h01
`define ISC_PROGIF_RST    8'h00
`define ISC_BAR_RST       32'h0000_0000
`define ISC_SUBSYS_RST    32'h0000_0000
// Arbitrary neutral identifiers, not any maker's codes
`define ISC_SUBSYS_DEF_ID  16'h5A5A
`define ISC_SUBSYS_DEF_VID 16'hA5A5
`define ISC_LEG_PRI_BASE  12'h01F
`define ISC_LEG_SEC_BASE  12'h017

`endif

/* File: isc_pkg.sv */
// Types shared by the IDE strap configuration block.
// Assumes isc_defines.svh is on the include path.
`default_nettype none
package isc_pkg;
   typedef struct packed {
      logic option_rom_enable_strap;
      logic subsystem_id_load_strap;
      logic disk_cycle_enable_strap;
      logic secondary_enable_strap;
      logic primary_enable_strap;
      logic default_mode_strap;
      logic native_capable_strap;
      logic raid_select_strap;
   } isc_strap_t;

   typedef struct packed {
      logic pri_access;
      logic sec_access;
      logic pri_native;
      logic sec_native;
      logic rom_support;
      logic cycles_on;
   } isc_chan_t;
endpackage : isc_pkg
`default_nettype wire

/* File: isc_strap_config.sv */
// Strap capture and configuration registers of a dual-channel IDE host,
// with an APB slave for software access.
// Assumes straps are stable around reset and all inputs are synchronous to pclk.
`include "isc_defines.svh"
`default_nettype none
module isc_strap_config (
   input  wire  logic               pclk,
   input  wire  logic               presetn,
   input  wire  logic               clk_en,
   input  wire  isc_pkg::isc_strap_t straps,
   input  wire  logic               psel,
   input  wire  logic               penable,
   input  wire  logic               pwrite,
   input  wire  logic [11:0]        paddr,
   input  wire  logic [31:0]        pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire  logic [15:0]        io_addr,
   input  wire  logic               pri_irq_req,
   input  wire  logic               sec_irq_req,
   output logic                     pri_task_file_hit,
   output logic                     sec_task_file_hit,
   output logic                     legacy_primary_interrupt,
   output logic                     legacy_secondary_interrupt,
   output logic                     native_interrupt,
   output logic [7:0]               sub_class,
   output isc_pkg::isc_chan_t       chan
);
   isc_pkg::isc_strap_t strap_r;
   isc_pkg::isc_strap_t strap_nxt;
   logic                captured_r;
   logic                captured_nxt;
   logic [1:0]          cmd_r;
   logic [1:0]          cmd_nxt;
   logic [7:0]          progif_r;
   logic [7:0]          progif_nxt;
   logic [31:0]         bar_r   [4];
   logic [31:0]         bar_nxt [4];
   logic [31:0]         subsys_r;
   logic [31:0]         subsys_nxt;
   logic [31:0]         prdata_r;
   logic [31:0]         prdata_nxt;
   logic [7:0]          sub_class_r;
   logic [7:0]          sub_class_nxt;

   logic       wr_en;
   logic       rd_setup;
   logic       hit;
   logic       bar_hit;
   logic [1:0] bar_idx;
   logic       ide_mode;
   logic       native_cap;
   logic [7:0] progif_rd;
   logic [31:0] rd_word;

   assign ide_mode   = strap_r.raid_select_strap;
   assign native_cap = strap_r.native_capable_strap;

   // Zero wait states; a frozen clock enable stretches the access phase
   assign pready  = clk_en;
   assign wr_en   = clk_en & psel & penable & pwrite;
   assign rd_setup = clk_en & psel & ~penable;
   assign bar_hit = (paddr[11:4] == 8'h01) & (paddr[1:0] == 2'b00);
   assign bar_idx = paddr[3:2];
   assign hit     = bar_hit
                  | (paddr == `ISC_OFF_STRAP)
                  | (paddr == `ISC_OFF_CMD)
                  | (paddr == `ISC_OFF_CLASS)
                  | (paddr == `ISC_OFF_SUBSYS)
                  | (paddr == `ISC_OFF_CHAN);
   assign pslverr = psel & penable & ~hit;

   // Interface register as software sees it
   always_comb begin
      if (!ide_mode) begin
         progif_rd = 8'h00;
      end else begin
         progif_rd = progif_r;
      end
   end

   // Read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      if (bar_hit) begin
         rd_word = native_cap ? bar_r[bar_idx] : 32'h0000_0000;
      end else begin
         unique case (paddr)
            `ISC_OFF_STRAP:  rd_word = {24'h00_0000, strap_r};
            `ISC_OFF_CMD:    rd_word = {30'h0000_0000, cmd_r};
            `ISC_OFF_CLASS:  rd_word = {16'h0000, sub_class_r, progif_rd};
            `ISC_OFF_SUBSYS: rd_word = subsys_r;
            `ISC_OFF_CHAN: begin
               rd_word[`ISC_CHAN_PRI_BIT] = strap_r.primary_enable_strap;
               rd_word[`ISC_CHAN_SEC_BIT] = strap_r.secondary_enable_strap;
            end
            default:         rd_word = 32'h0000_0000;
         endcase
      end
   end

   // Next state of the capture flags and configuration registers
   always_comb begin
      strap_nxt     = strap_r;
      captured_nxt  = captured_r;
      cmd_nxt       = cmd_r;
      progif_nxt    = progif_r;
      bar_nxt       = bar_r;
      subsys_nxt    = subsys_r;
      sub_class_nxt = sub_class_r;
      prdata_nxt    = prdata_r;

      if (!captured_r) begin
         // First enabled edge after reset release: sample straps once
         strap_nxt    = straps;
         captured_nxt = 1'b1;
         sub_class_nxt = straps.raid_select_strap ? `ISC_SUBCLASS_IDE
                                                  : `ISC_SUBCLASS_RAID;
         cmd_nxt[`ISC_CMD_IO_BIT]  = straps.disk_cycle_enable_strap;
         cmd_nxt[`ISC_CMD_ROM_BIT] = straps.option_rom_enable_strap;
         progif_nxt = `ISC_PROGIF_RST;
         if (straps.native_capable_strap) begin
            progif_nxt[`ISC_PI_PRI_CAP] = 1'b1;
            progif_nxt[`ISC_PI_SEC_CAP] = 1'b1;
            progif_nxt[`ISC_PI_PRI_NAT] = ~straps.default_mode_strap;
            progif_nxt[`ISC_PI_SEC_NAT] = ~straps.default_mode_strap;
         end
         if (straps.subsystem_id_load_strap) begin
            subsys_nxt = {`ISC_SUBSYS_DEF_ID, `ISC_SUBSYS_DEF_VID};
         end
      end else if (wr_en) begin
         if (bar_hit) begin
            bar_nxt[bar_idx] = pwdata;
         end else begin
            unique case (paddr)
               `ISC_OFF_CMD: begin
                  // Strap-forced cycles cannot be switched off
                  cmd_nxt[`ISC_CMD_IO_BIT] = pwdata[`ISC_CMD_IO_BIT]
                                           | strap_r.disk_cycle_enable_strap;
                  // ROM enable only exists when the board fitted a ROM
                  cmd_nxt[`ISC_CMD_ROM_BIT] = pwdata[`ISC_CMD_ROM_BIT]
                                            & strap_r.option_rom_enable_strap;
               end
               `ISC_OFF_CLASS: begin
                  // Mode bits move only in IDE mode with native capability
                  if (ide_mode && native_cap) begin
                     progif_nxt[`ISC_PI_PRI_NAT] = pwdata[`ISC_PI_PRI_NAT];
                     progif_nxt[`ISC_PI_SEC_NAT] = pwdata[`ISC_PI_SEC_NAT];
                  end
               end
               `ISC_OFF_SUBSYS: subsys_nxt = pwdata;
               default: begin
               end
            endcase
         end
      end

      if (rd_setup) begin
         prdata_nxt = rd_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // Every configuration register back to its initial value
         strap_r     <= '0;
         captured_r  <= 1'b0;
         cmd_r       <= 2'b00;
         progif_r    <= `ISC_PROGIF_RST;
         bar_r       <= '{default: `ISC_BAR_RST};
         subsys_r    <= `ISC_SUBSYS_RST;
         sub_class_r <= `ISC_SUBCLASS_RAID;
         prdata_r    <= 32'h0000_0000;
      end else if (clk_en) begin
         strap_r     <= strap_nxt;
         captured_r  <= captured_nxt;
         cmd_r       <= cmd_nxt;
         progif_r    <= progif_nxt;
         bar_r       <= bar_nxt;
         subsys_r    <= subsys_nxt;
         sub_class_r <= sub_class_nxt;
         prdata_r    <= prdata_nxt;
      end
   end

   assign prdata    = prdata_r;
   assign sub_class = sub_class_r;

   // Channel gating derived from held straps, the command register and the interface register
   always_comb begin
      chan.cycles_on   = cmd_r[`ISC_CMD_IO_BIT];
      chan.rom_support = cmd_r[`ISC_CMD_ROM_BIT];
      chan.pri_access  = captured_r & strap_r.primary_enable_strap
                       & cmd_r[`ISC_CMD_IO_BIT];
      chan.sec_access  = captured_r & ~strap_r.secondary_enable_strap
                       & cmd_r[`ISC_CMD_IO_BIT];
      chan.pri_native  = native_cap & ide_mode & progif_r[`ISC_PI_PRI_NAT];
      chan.sec_native  = native_cap & ide_mode & progif_r[`ISC_PI_SEC_NAT];
   end

   // Legacy task file windows
   assign pri_task_file_hit = chan.pri_access & ~chan.pri_native
                            & (io_addr[15:4] == `ISC_LEG_PRI_BASE);
   assign sec_task_file_hit = chan.sec_access & ~chan.sec_native
                            & (io_addr[15:4] == `ISC_LEG_SEC_BASE);

   // Interrupt routing: legacy lines unless the channel runs native
   assign legacy_primary_interrupt   = pri_irq_req & chan.pri_access
                                     & ~chan.pri_native;
   assign legacy_secondary_interrupt = sec_irq_req & chan.sec_access
                                     & ~chan.sec_native;
   assign native_interrupt = (pri_irq_req & chan.pri_access & chan.pri_native)
                           | (sec_irq_req & chan.sec_access & chan.sec_native);
endmodule : isc_strap_config
`default_nettype wire

/* File: isc_strap_config_properties.sv */
// Checker for the strap block, watching only its top ports.
// Assumes straps settle during reset; bound from the bench.
`default_nettype none
module isc_strap_config_properties (
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                clk_en,
   input wire isc_pkg::isc_strap_t straps,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pwrite,
   input wire logic [11:0]         paddr,
   input wire logic [31:0]         prdata,
   input wire logic [15:0]         io_addr,
   input wire logic                pri_irq_req,
   input wire logic                pri_task_file_hit,
   input wire logic                legacy_primary_interrupt,
   input wire logic                native_interrupt,
   input wire logic [7:0]          sub_class,
   input wire isc_pkg::isc_chan_t  chan
);
   logic                done_r;
   isc_pkg::isc_strap_t s_r;
   // Own copy of the captured straps, so later pin motion cannot mislead
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_r <= 1'b0;
         s_r    <= '0;
      end else if (clk_en && !done_r) begin
         done_r <= 1'b1;
         s_r    <= straps;
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_rd(logic [11:0] a);
      psel && !penable && !pwrite && paddr == a ##1 psel && penable;
   endsequence
   property p_sub; done_r |-> sub_class == (s_r.raid_select_strap ? 8'h01 : 8'h04); endproperty
   a_sub: assert property (p_sub) else $error("sub class wrong");
   property p_bar; done_r && !s_r.native_capable_strap ##0 s_rd(12'h010) |-> prdata == 32'h0;
   endproperty
   a_bar: assert property (p_bar) else $error("base address not zero");
   property p_irq; done_r && !s_r.native_capable_strap |-> !native_interrupt
      && legacy_primary_interrupt == (pri_irq_req && chan.pri_access); endproperty
   a_irq: assert property (p_irq) else $error("legacy interrupt wrong");
   property p_dec; done_r && !s_r.native_capable_strap |-> !chan.pri_native && !chan.sec_native
      && pri_task_file_hit == (io_addr[15:4] == 12'h01F && chan.pri_access); endproperty
   a_dec: assert property (p_dec) else $error("legacy decode wrong");
   property p_boot; $rose(done_r) && s_r.native_capable_strap && s_r.raid_select_strap
      |-> chan.pri_native == !s_r.default_mode_strap; endproperty
   a_boot: assert property (p_boot) else $error("boot mode wrong");
   property p_raid; done_r && !s_r.raid_select_strap ##0 s_rd(12'h008) |-> prdata[7:0] == 8'h00;
   endproperty
   a_raid: assert property (p_raid) else $error("interface byte not zero");
   property p_pri; done_r && !s_r.primary_enable_strap
      |-> !chan.pri_access && !legacy_primary_interrupt && !pri_task_file_hit; endproperty
   a_pri: assert property (p_pri) else $error("primary not blocked");
   property p_disk; done_r && s_r.disk_cycle_enable_strap |-> chan.cycles_on; endproperty
   a_disk: assert property (p_disk) else $error("disk cycles off");
endmodule : isc_strap_config_properties
`default_nettype wire

/* File: isc_strap_board.sv */
// Board strap model: a fitted pull-down reads low, an open jumper high.
// Assumes the bench changes the fitting only when it means to.
`default_nettype none
module isc_strap_board (
   input  wire logic [7:0]          pulldown_fitted,
   output wire isc_pkg::isc_strap_t straps
);
   // Open jumpers float high through the pin's weak pull-up
   assign straps = ~pulldown_fitted;
endmodule : isc_strap_board
`default_nettype wire

/* File: tb_isc_strap_config.sv */
// Bench: boots the block under several jumper sets and probes it over APB.
// Assumes clk_en stays high, so every access has no wait state.
`include "isc_defines.svh"
`default_nettype none
module tb_isc_strap_config;
   timeunit 1ns;
   timeprecision 1ps;
   logic                pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, err;
   logic                pri_irq_req, sec_irq_req, pri_task_file_hit, sec_task_file_hit;
   logic                legacy_primary_interrupt, legacy_secondary_interrupt, native_interrupt;
   logic                nat, nmb, raid;
   logic [11:0]         paddr;
   logic [15:0]         io_addr;
   logic [31:0]         pwdata, prdata, rd;
   logic [7:0]          sub_class, fitted, sub;
   // Last set boots IDE, native capable, native by default
   logic [7:0]          tbl [5] = '{8'h00, 8'hFF, 8'hE8, 8'h56, 8'hB4};
   isc_pkg::isc_strap_t straps, s;
   isc_pkg::isc_chan_t  chan;
   int                  miscompares = 0;
   int                  samples_checked = 0;
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   isc_strap_board brd (.pulldown_fitted(fitted), .straps);
   isc_strap_config dut (.pclk, .presetn, .clk_en, .straps, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .io_addr, .pri_irq_req, .sec_irq_req,
      .pri_task_file_hit, .sec_task_file_hit, .legacy_primary_interrupt,
      .legacy_secondary_interrupt, .native_interrupt, .sub_class, .chan);
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // Request held until pready is seen high, then released
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         miscompares++;
         finish_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(what, exp, rd);
   endtask : rchk
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {clk_en, pri_irq_req, sec_irq_req} = 3'h7;
      io_addr = 16'h01F3;
      fitted = tbl[0];
      foreach (tbl[i]) begin
         @(posedge pclk);
         presetn <= 1'b0;
         fitted <= tbl[i];
         repeat (3) @(posedge pclk);
         chk("reset sub", 32'h04, {24'h0, sub_class});
         chk("reset chan", 32'h0, {26'h0, chan});
         s = ~tbl[i];
         {raid, nat} = {s.raid_select_strap, s.native_capable_strap};
         nmb = raid & nat & ~s.default_mode_strap;
         sub = raid ? 8'h01 : 8'h04;
         presetn <= 1'b1;
         @(posedge pclk);
         @(posedge pclk);
         fitted <= ~tbl[i];
         rchk("image", 12'h000, {24'h0, s});
         rchk("class", 12'h008, {16'h0, sub, raid ? {4'h0, nat, nmb, nat, nmb} : 8'h0});
         rchk("chan", 12'h050, {28'h0, s.secondary_enable_strap, s.primary_enable_strap, 2'h0});
         rchk("subsys", 12'h02C, s.subsystem_id_load_strap ?
              {`ISC_SUBSYS_DEF_ID, `ISC_SUBSYS_DEF_VID} : 32'h0);
         rchk("cmd", 12'h004, {30'h0, s.option_rom_enable_strap, s.disk_cycle_enable_strap});
         apb(1'b1, 12'h004, 32'h0);
         rchk("cmd0", 12'h004, {31'h0, s.disk_cycle_enable_strap});
         apb(1'b1, 12'h004, 32'h3);
         rchk("cmd3", 12'h004, {30'h0, s.option_rom_enable_strap, 1'b1});
         chk("chan", {26'h0, s.primary_enable_strap, ~s.secondary_enable_strap, nmb, nmb,
             s.option_rom_enable_strap, 1'b1}, {26'h0, chan});
         chk("hit", {31'h0, s.primary_enable_strap & ~nmb}, {31'h0, pri_task_file_hit});
         chk("pri irq", {31'h0, s.primary_enable_strap & ~nmb},
             {31'h0, legacy_primary_interrupt});
         chk("sec irq", {31'h0, ~s.secondary_enable_strap & ~nmb},
             {31'h0, legacy_secondary_interrupt});
         chk("nat irq", {31'h0, nmb & (s.primary_enable_strap | ~s.secondary_enable_strap)},
             {31'h0, native_interrupt});
         io_addr <= 16'h0173;
         @(posedge pclk);
         chk("sec hit", {31'h0, ~s.secondary_enable_strap & ~nmb},
             {31'h0, sec_task_file_hit});
         io_addr <= 16'h01F3;
         apb(1'b1, 12'h010, 32'h0000_01F0);
         rchk("bar", 12'h010, nat ? 32'h0000_01F0 : 32'h0);
         apb(1'b1, 12'h008, 32'h0000_0005);
         rchk("progif", 12'h008, {16'h0, sub, (raid && nat) ? 8'h0F : 8'h00});
         rchk("unmapped", 12'h0FC, 32'h0);
         chk("unmapped err", 32'h1, {31'h0, err});
      end
      finish_test();
   end
endmodule : tb_isc_strap_config
bind isc_strap_config isc_strap_config_properties chk_i (.pclk, .presetn, .clk_en, .straps,
   .psel, .penable, .pwrite, .paddr, .prdata, .io_addr, .pri_irq_req, .pri_task_file_hit,
   .legacy_primary_interrupt, .native_interrupt, .sub_class, .chan);
`default_nettype wire
